// >>> core/amd_addr_decoder.sv
// amd_addr_decoder: opcode, postbyte and extension decode with effective-address forming.
// assumes the queue, opcode map, register file and memory port share sys_clk_i.
`timescale 1ns/100ps
module amd_addr_decoder
   import amd_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // instruction queue
   input  wire logic [7:0]  q_byte_i,
   input  wire logic        q_valid_i,
   output logic             q_ready_o,
   // opcode map
   input  wire amd_class_e  op_class_i,
   // core registers
   input  wire logic [15:0] reg_x_i,
   input  wire logic [15:0] reg_y_i,
   input  wire logic [15:0] reg_sp_i,
   input  wire logic [15:0] reg_pc_i,
   input  wire logic [7:0]  acc_a_i,
   input  wire logic [7:0]  acc_b_i,
   // pointer read port
   output logic             mem_req_o,
   output logic [15:0]      mem_addr_o,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic        mem_ack_i,
   // decode results
   output logic [7:0]       opcode_o,
   output logic             page2_o,
   output logic             opcode_valid_o,
   output amd_mode_e        mode_o,
   output logic             ea_valid_o,
   output logic [15:0]      ea_o,
   output logic [15:0]      operand_o,
   output logic             no_mem_o,
   output logic [7:0]       postbyte_o,
   output logic             wb_valid_o,
   output logic [1:0]       wb_sel_o,
   output logic [15:0]      wb_value_o,
   output logic             illegal_o
);

   amd_state_e  state;
   amd_state_e  next_state;
   logic [15:0] full_address_mode;
   logic [1:0]  ext_left;
   logic [1:0]  next_need;
   logic [7:0]  ptr_hi;
   logic        take;
   logic [15:0] next_ea;
   amd_mode_e   next_mode;
   logic        next_ind;
   logic        next_wb;
   logic [15:0] next_wbv;
   logic        next_ill;
   logic [1:0]  rr;
   logic [15:0] base;
   logic [15:0] step;

   assign take = q_valid_i && q_ready_o;

   // base register pick shared by all indexed forms
   function automatic logic [15:0] pick_base(input logic [1:0] sel);
      case (sel)
         AMD_RR_X:  pick_base = reg_x_i;
         AMD_RR_Y:  pick_base = reg_y_i;
         AMD_RR_SP: pick_base = reg_sp_i;
         default:   pick_base = reg_pc_i;
      endcase
   endfunction : pick_base

   // extension count implied by an index postbyte
   function automatic logic [1:0] idx_need(input logic [7:0] pb);
      if (!pb[AMD_PB_LONG] || pb[7:5] != 3'h7 || pb[AMD_PB_ACC]) begin
         idx_need = 2'h0;
      end else if (!pb[1]) begin
         idx_need = 2'h1;
      end else begin
         idx_need = 2'h2;
      end
   endfunction : idx_need

   // extension count implied by the opcode class
   always_comb begin
      case (op_class_i)
         CL_IMM8, CL_DIR, CL_REL8:   next_need = 2'h1;
         CL_IMM16, CL_EXT, CL_REL16: next_need = 2'h2;
         default:                    next_need = 2'h0;
      endcase
   end

   // sequence control
   always_comb begin
      next_state = state;
      case (state)
         ST_OPC: begin
            if (take && !(q_byte_i == AMD_PAGE2_PREFIX && !page2_o)) begin
               next_state = ST_CLASS;
            end
         end
         ST_CLASS: begin
            if (op_class_i == CL_IDX || op_class_i == CL_XFER || op_class_i == CL_LOOP) begin
               next_state = ST_POST;
            end else if (next_need != 2'h0) begin
               next_state = ST_EXT;
            end else begin
               next_state = ST_CALC;
            end
         end
         ST_POST: begin
            if (take) begin
               if (op_class_i == CL_LOOP ||
                   (op_class_i == CL_IDX && idx_need(q_byte_i) != 2'h0)) begin
                  next_state = ST_EXT;
               end else begin
                  next_state = ST_CALC;
               end
            end
         end
         ST_EXT: begin
            if (take && ext_left == 2'h1) begin
               next_state = ST_CALC;
            end
         end
         ST_CALC:   next_state = next_ind ? ST_PTR_HI : ST_DONE;
         ST_PTR_HI: next_state = mem_ack_i ? ST_PTR_LO : ST_PTR_HI;
         ST_PTR_LO: next_state = mem_ack_i ? ST_DONE : ST_PTR_LO;
         default:   next_state = ST_OPC;
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state <= ST_OPC;
      end else begin
         state <= next_state;
      end
   end

   // queue ready from the state being entered, so it stays a flop
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q_ready_o <= 1'b0;
      end else begin
         q_ready_o <= next_state == ST_OPC || next_state == ST_POST || next_state == ST_EXT;
      end
   end

   // opcode and page capture
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         opcode_o       <= AMD_BYTE_RST;
         page2_o        <= 1'b0;
         opcode_valid_o <= 1'b0;
      end else begin
         opcode_valid_o <= 1'b0;
         if (state == ST_OPC && take) begin
            if (q_byte_i == AMD_PAGE2_PREFIX && !page2_o) begin
               page2_o <= 1'b1;
            end else begin
               opcode_o       <= q_byte_i;
               opcode_valid_o <= 1'b1;
            end
         end else if (state == ST_DONE) begin
            page2_o <= 1'b0;
         end
      end
   end

   // postbyte and extension bytes; earlier byte lands high, as words are big-endian
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         postbyte_o <= AMD_BYTE_RST;
         full_address_mode        <= AMD_ADDR_RST;
         ext_left   <= 2'h0;
      end else if (state == ST_CLASS) begin
         full_address_mode      <= AMD_ADDR_RST;
         ext_left <= next_need;
      end else if (state == ST_POST && take) begin
         postbyte_o <= q_byte_i;
         ext_left   <= (op_class_i == CL_LOOP) ? 2'h1 : idx_need(q_byte_i);
      end else if (state == ST_EXT && take) begin
         full_address_mode      <= {full_address_mode[7:0], q_byte_i};
         ext_left <= ext_left - 2'h1;
      end
   end

   // effective address forming; all sums wrap at 16 bits
   always_comb begin
      next_ea   = AMD_ADDR_RST;
      next_mode = AM_REGISTER_OPERAND;
      next_ind  = 1'b0;
      next_wb   = 1'b0;
      next_wbv  = AMD_ADDR_RST;
      next_ill  = 1'b0;
      rr        = postbyte_o[AMD_PB_RR2_LO +: 2];
      base      = pick_base(rr);
      step      = AMD_ADDR_RST;
      case (op_class_i)
         CL_IMM8, CL_IMM16: next_mode = AM_INLINE_OPERAND;
         CL_DIR: begin
            next_mode = AM_DIRECT;
            next_ea   = {8'h00, full_address_mode[7:0]};
         end
         CL_EXT: begin
            next_mode = AM_FULL_ADDRESS;
            next_ea   = full_address_mode;
         end
         CL_REL8: begin
            next_mode = AM_RELATIVE;
            next_ea   = reg_pc_i + {{8{full_address_mode[7]}}, full_address_mode[7:0]};
         end
         CL_REL16: begin
            next_mode = AM_RELATIVE;
            next_ea   = reg_pc_i + full_address_mode;
         end
         CL_XFER, CL_LOOP: next_mode = AM_POSTBYTE_OP;
         CL_IDX: begin
            if (!postbyte_o[AMD_PB_LONG]) begin
               rr        = postbyte_o[AMD_PB_RR_LO +: 2];
               base      = pick_base(rr);
               next_mode = AM_SHORT_INDEXED;
               next_ea   = base + {{11{postbyte_o[4]}}, postbyte_o[4:0]};
            end else if (postbyte_o[7:5] != 3'h7) begin
               rr        = postbyte_o[AMD_PB_RR_LO +: 2];
               base      = pick_base(rr);
               next_mode = AM_AUTO_INDEXED;
               next_ill  = rr == AMD_RR_PC;
               // low nibble 0..7 means +1..+8, 8..15 means -8..-1
               step = postbyte_o[3] ? {12'hfff, postbyte_o[3:0]}
                                    : {12'h000, postbyte_o[3:0]} + 16'h0001;
               next_wbv = base + step;
               next_wb  = !next_ill;
               next_ea  = postbyte_o[AMD_PB_POST] ? base : next_wbv;
            end else if (!postbyte_o[AMD_PB_ACC]) begin
               if (!postbyte_o[1]) begin
                  next_mode = AM_NINE_BIT_INDEXED;
                  next_ea   = base + {{8{postbyte_o[0]}}, full_address_mode[7:0]};
               end else begin
                  next_ind  = postbyte_o[0];
                  next_mode = postbyte_o[0] ? AM_OFFSET_INDIRECT : AM_SIXTEEN_INDEXED;
                  next_ea   = base + full_address_mode;
               end
            end else begin
               next_mode = AM_ACC_INDEXED;
               case (postbyte_o[1:0])
                  AMD_AA_A: next_ea = base + {8'h00, acc_a_i};
                  AMD_AA_B: next_ea = base + {8'h00, acc_b_i};
                  AMD_AA_D: next_ea = base + {acc_a_i, acc_b_i};
                  default: begin
                     next_mode = AM_DOUBLE_ACC_IND;
                     next_ind  = 1'b1;
                     next_ea   = base + {acc_a_i, acc_b_i};
                  end
               endcase
            end
         end
         default: next_mode = AM_REGISTER_OPERAND;
      endcase
   end

   // result register; pointer word arrives high byte first
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ea_o      <= AMD_ADDR_RST;
         mode_o    <= AM_REGISTER_OPERAND;
         operand_o <= AMD_ADDR_RST;
         no_mem_o  <= 1'b0;
         illegal_o <= 1'b0;
         ptr_hi    <= AMD_BYTE_RST;
      end else if (state == ST_CALC) begin
         ea_o      <= next_ea;
         mode_o    <= next_mode;
         operand_o <= (op_class_i == CL_IMM8) ? {8'h00, full_address_mode[7:0]} : full_address_mode;
         // inherent, immediate and postbyte ops leave memory alone
         no_mem_o  <= op_class_i == CL_INH || op_class_i == CL_IMM8 ||
                      op_class_i == CL_IMM16 || op_class_i == CL_XFER ||
                      op_class_i == CL_LOOP;
         illegal_o <= next_ill;
      end else if (state == ST_PTR_HI && mem_ack_i) begin
         ptr_hi <= mem_rdata_i;
      end else if (state == ST_PTR_LO && mem_ack_i) begin
         ea_o <= {ptr_hi, mem_rdata_i};
      end
   end

   // pointer read requests; odd addresses are fine, no alignment check
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mem_req_o  <= 1'b0;
         mem_addr_o <= AMD_ADDR_RST;
      end else if (state == ST_CALC && next_ind) begin
         mem_req_o  <= 1'b1;
         mem_addr_o <= next_ea;
      end else if (state == ST_PTR_HI && mem_ack_i) begin
         mem_addr_o <= mem_addr_o + 16'h0001;
      end else if (state == ST_PTR_LO && mem_ack_i) begin
         mem_req_o <= 1'b0;
      end
   end

   // completion pulse and index write-back
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ea_valid_o <= 1'b0;
         wb_valid_o <= 1'b0;
         wb_sel_o   <= AMD_RR_X;
         wb_value_o <= AMD_ADDR_RST;
      end else begin
         ea_valid_o <= next_state == ST_DONE;
         wb_valid_o <= state == ST_CALC && op_class_i == CL_IDX && next_wb;
         if (state == ST_CALC) begin
            wb_sel_o   <= rr;
            wb_value_o <= next_wbv;
         end
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   direct_page_a: assert property (ea_valid_o && mode_o == AM_DIRECT |-> ea_o[15:8] == 8'h00)
      else $error("direct address upper byte not zero");
   ptr_order_a: assert property (state == ST_PTR_HI && mem_ack_i |=>
                                 mem_addr_o == $past(mem_addr_o) + 16'h0001)
      else $error("pointer low byte not at next address");
   ptr_use_a: assert property (state == ST_PTR_LO && mem_ack_i |=>
                               ea_o == {ptr_hi, $past(mem_rdata_i)})
      else $error("pointer not used as operand address");
   inh_nomem_a: assert property (ea_valid_o && mode_o == AM_REGISTER_OPERAND |->
                                 no_mem_o && !mem_req_o)
      else $error("inherent op touched memory");
   pc_auto_a: assert property (ea_valid_o && mode_o == AM_AUTO_INDEXED |->
                               postbyte_o[7:6] != AMD_RR_PC)
      else $error("auto form based on pc");
   post_form_a: assert property (wb_valid_o && postbyte_o[AMD_PB_POST] |->
                                 ea_o != wb_value_o)
      else $error("post form used adjusted address");
   page_two_a: assert property (state == ST_OPC && take && !page2_o &&
                                q_byte_i == AMD_PAGE2_PREFIX |=> page2_o && state == ST_OPC)
      else $error("prefix did not open second page");
   ext_count_a: assert property (state == ST_CLASS && op_class_i == CL_EXT |=>
                                 state == ST_EXT ##0 ext_left == 2'h2)
      else $error("extended mode not two extension bytes");
   no_fault_a: assert property (ea_valid_o && mode_o != AM_AUTO_INDEXED |-> !illegal_o)
      else $error("fault raised outside auto form");
   short_ext_a: assert property (state == ST_POST && take && op_class_i == CL_IDX &&
                                 !q_byte_i[AMD_PB_LONG] |=> state == ST_CALC)
      else $error("short offset fetched an extension");

   ind_done_c: cover property (ea_valid_o && mode_o == AM_OFFSET_INDIRECT);
   dind_done_c: cover property (ea_valid_o && mode_o == AM_DOUBLE_ACC_IND);
   auto_wb_c: cover property (wb_valid_o);
   page_two_c: cover property (opcode_valid_o && page2_o);

endmodule : amd_addr_decoder

// >>> core/amd_pkg.sv
// amd_pkg: shared constants and types for the addressing-mode decoder.
// assumes one core clock domain; opcode classes come from an external opcode map.
package amd_pkg;

   // opcode prefix that opens the second opcode page
   localparam logic [7:0] AMD_PAGE2_PREFIX = 8'h18;

   // base register field codes
   localparam logic [1:0] AMD_RR_X  = 2'h0;
   localparam logic [1:0] AMD_RR_Y  = 2'h1;
   localparam logic [1:0] AMD_RR_SP = 2'h2;
   localparam logic [1:0] AMD_RR_PC = 2'h3;

   // accumulator select field codes
   localparam logic [1:0] AMD_AA_A    = 2'h0;
   localparam logic [1:0] AMD_AA_B    = 2'h1;
   localparam logic [1:0] AMD_AA_D    = 2'h2;
   localparam logic [1:0] AMD_AA_DIND = 2'h3;

   // index postbyte field positions
   localparam int AMD_PB_RR_LO   = 6;  // rr in rrXppppp / rr0nnnnn forms
   localparam int AMD_PB_RR2_LO  = 3;  // rr in 111rrXXX forms
   localparam int AMD_PB_LONG    = 5;  // 0 = 5-bit constant offset
   localparam int AMD_PB_POST    = 4;  // auto form: 1 = post
   localparam int AMD_PB_ACC     = 2;  // 111rr form: 1 = accumulator offset

   // reset values
   localparam logic [15:0] AMD_ADDR_RST = 16'h0000;
   localparam logic [7:0]  AMD_BYTE_RST = 8'h00;

   // opcode class reported by the opcode map for the current opcode
   typedef enum logic [3:0] {
      CL_INH   = 4'h0,
      CL_IMM8  = 4'h1,
      CL_IMM16 = 4'h2,
      CL_DIR   = 4'h3,
      CL_EXT   = 4'h4,
      CL_REL8  = 4'h5,
      CL_REL16 = 4'h6,
      CL_IDX   = 4'h7,
      CL_XFER  = 4'h8,
      CL_LOOP  = 4'h9
   } amd_class_e;

   // resolved addressing mode
   typedef enum logic [3:0] {
      AM_REGISTER_OPERAND = 4'h0,
      AM_INLINE_OPERAND   = 4'h1,
      AM_DIRECT           = 4'h2,
      AM_FULL_ADDRESS     = 4'h3,
      AM_RELATIVE         = 4'h4,
      AM_SHORT_INDEXED    = 4'h5,
      AM_NINE_BIT_INDEXED = 4'h6,
      AM_SIXTEEN_INDEXED  = 4'h7,
      AM_OFFSET_INDIRECT  = 4'h8,
      AM_DOUBLE_ACC_IND   = 4'h9,
      AM_AUTO_INDEXED     = 4'ha,
      AM_ACC_INDEXED      = 4'hb,
      AM_POSTBYTE_OP      = 4'hc
   } amd_mode_e;

   // decoder sequence
   typedef enum logic [2:0] {
      ST_OPC    = 3'h0,
      ST_CLASS  = 3'h1,
      ST_POST   = 3'h2,
      ST_EXT    = 3'h3,
      ST_CALC   = 3'h4,
      ST_PTR_HI = 3'h5,
      ST_PTR_LO = 3'h6,
      ST_DONE   = 3'h7
   } amd_state_e;

endpackage : amd_pkg

// >>> sim/amd_mem_model.sv
// amd_mem_model: byte memory behind the decoder's pointer read port.
// assumes one outstanding read; its byte pattern is known to the bench.
`timescale 1ns/100ps
module amd_mem_model (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   // read port
   input  wire logic        mem_req_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic        slow_i,
   output logic [7:0]       mem_rdata_o,
   output logic             mem_ack_o
);
   logic [1:0] wait_cnt;
   logic [7:0] last;

   // one ack per byte, never two in a row; slow answers after three idle cycles
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !mem_req_i || mem_ack_o) begin
         mem_ack_o <= 1'b0;
         wait_cnt  <= 2'h0;
         if (sys_rst_i) last <= 8'h00;
      end else if (!slow_i || wait_cnt == 2'h3) begin
         mem_ack_o <= 1'b1;
         last      <= mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h5a;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end

   // outside an ack the bus shows junk, so a stale byte is never mistaken for data
   assign mem_rdata_o = mem_ack_o ? last : ~last;
endmodule : amd_mem_model

// >>> sim/tb_amd_addr_decoder.sv
// tb_amd_addr_decoder: self-checking bench for the addressing-mode decoder.
// assumes amd_pkg, amd_addr_decoder and amd_mem_model are compiled first.
`timescale 1ns/100ps
module tb_amd_addr_decoder;
   import amd_pkg::*;

   // one expected decode result; chk: ea, operand, no_mem, illegal, postbyte
   typedef struct {
      amd_mode_e   mode;
      logic [15:0] ea;
      logic [15:0] opnd;
      logic [7:0]  opc;
      logic [7:0]  pb;
      logic        pg2;
      logic        nomem;
      logic        ill;
      logic [4:0]  chk;
   } amd_tb_exp_s;

   logic        sys_clk_i, sys_rst_i, q_valid_i, q_ready_o, slow;
   logic [7:0]  q_byte_i, acc_a_i, acc_b_i, mem_rdata_i, opcode_o, postbyte_o, ra, rb;
   logic [15:0] reg_x_i, reg_y_i, reg_sp_i, reg_pc_i, mem_addr_o, ea_o, operand_o;
   logic [15:0] wb_value_o, rx, ry, rs, rp;
   logic        mem_req_o, mem_ack_i, page2_o, ea_valid_o, no_mem_o, wb_valid_o, illegal_o;
   logic [1:0]  wb_sel_o;
   logic        opcode_valid_o;
   amd_class_e  op_class_i;
   amd_mode_e   mode_o;
   amd_tb_exp_s exp_q[$];
   logic [17:0] wb_q[$];
   int          err_count, checks;

   amd_addr_decoder amd_addr_decoder_inst (
      .sys_clk_i, .sys_rst_i, .q_byte_i, .q_valid_i, .q_ready_o, .op_class_i,
      .reg_x_i, .reg_y_i, .reg_sp_i, .reg_pc_i, .acc_a_i, .acc_b_i,
      .mem_req_o, .mem_addr_o, .mem_rdata_i, .mem_ack_i, .opcode_o, .page2_o,
      .opcode_valid_o, .mode_o, .ea_valid_o, .ea_o, .operand_o, .no_mem_o,
      .postbyte_o, .wb_valid_o, .wb_sel_o, .wb_value_o, .illegal_o);

   amd_mem_model amd_mem_model_inst (
      .sys_clk_i, .sys_rst_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .slow_i(slow), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));

   // 20 MHz core clock
   always #25 sys_clk_i = ~sys_clk_i;

   function automatic logic [15:0] base(input logic [1:0] rr);
      return rr == AMD_RR_X ? rx : rr == AMD_RR_Y ? ry : rr == AMD_RR_SP ? rs : rp;
   endfunction : base

   // same byte pattern the memory model serves; words are big-endian
   function automatic logic [15:0] ptr(input logic [15:0] a);
      logic [15:0] b;
      b = a + 16'h1;
      return {a[7:0] ^ a[15:8] ^ 8'h5a, b[7:0] ^ b[15:8] ^ 8'h5a};
   endfunction : ptr

   function automatic amd_tb_exp_s mk(input amd_mode_e m, input logic [15:0] ea, opnd,
                                      input logic [4:0] chk);
      return '{m, ea, opnd, 8'h00, 8'h00, 1'b0, m == AM_REGISTER_OPERAND, 1'b0, chk};
   endfunction : mk

   // random opcode, kept off the page prefix
   function automatic logic [7:0] rop();
      logic [7:0] o;
      o = 8'($urandom);
      return o == AMD_PAGE2_PREFIX ? 8'h01 : o;
   endfunction : rop

   task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp16

   task automatic cmp_mode(input amd_mode_e e, input amd_mode_e g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value mode expected %h seen %h", e, g);
      end
   endtask : cmp_mode

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task automatic give_up(input string w);
      err_count++;
      $display("wrong value %s wait expected done seen timeout", w);
      print_verdict();
   endtask : give_up

   // fresh register file per loop pass, held until its results are out
   // wrap puts y just under the top of the map so sums roll over
   task automatic new_regs(input bit wrap = 1'b0);
      rx = 16'($urandom);
      ry = wrap ? 16'hfffc : 16'($urandom);
      rs = 16'($urandom);
      rp = 16'($urandom);
      ra = 8'h80 | 8'($urandom);
      rb = 8'($urandom);
      {reg_x_i, reg_y_i, reg_sp_i, reg_pc_i} <= {rx, ry, rs, rp};
      {acc_a_i, acc_b_i} <= {ra, rb};
   endtask : new_regs

   // hold the byte until an edge samples ready high
   task automatic put_byte(input logic [7:0] b);
      int n;
      q_byte_i  <= b;
      q_valid_i <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (q_ready_o !== 1'b1 && n < 200);
      if (q_ready_o !== 1'b1) give_up("queue");
   endtask : put_byte

   task automatic run(input amd_class_e cl, input logic [7:0] b[$], input amd_tb_exp_s e);
      int k;
      int n;
      k = b[0] == AMD_PAGE2_PREFIX ? 1 : 0;
      e.pg2 = k == 1;
      e.opc = b[k];
      e.pb = b.size() > k + 1 ? b[k + 1] : 8'h00;
      op_class_i <= cl;
      exp_q.push_back(e);
      foreach (b[i]) put_byte(b[i]);
      q_valid_i <= 1'b0;
      q_byte_i  <= ~q_byte_i;
      for (n = 0; n < 300 && exp_q.size() != 0; n++) @(posedge sys_clk_i);
      if (exp_q.size() != 0) give_up("result");
   endtask : run

   task automatic test_plain();
      logic [7:0] o, h, l;
      for (int i = 0; i < 4; i++) begin
         new_regs();
         o = rop();
         h = 8'($urandom);
         l = 8'($urandom);
         run(CL_INH, '{o}, mk(AM_REGISTER_OPERAND, 16'h0, 16'h0, 5'h04));
         run(CL_DIR, '{o, l}, mk(AM_DIRECT, {8'h00, l}, 16'h0, 5'h05));
         run(CL_EXT, '{o, h, l}, mk(AM_FULL_ADDRESS, {h, l}, 16'h0, 5'h05));
         run(CL_EXT, '{AMD_PAGE2_PREFIX, o, h, l},
             mk(AM_FULL_ADDRESS, {h, l}, 16'h0, 5'h01));
         run(CL_REL8, '{o, l}, mk(AM_RELATIVE, rp + {{8{l[7]}}, l}, 16'h0, 5'h01));
         run(CL_REL16, '{o, h, l}, mk(AM_RELATIVE, rp + {h, l}, 16'h0, 5'h01));
         run(CL_IMM8, '{o, l}, mk(AM_INLINE_OPERAND, 16'h0, {8'h00, l}, 5'h03));
         run(CL_IMM16, '{o, h, l}, mk(AM_INLINE_OPERAND, 16'h0, {h, l}, 5'h03));
         run(CL_XFER, '{o, h}, mk(AM_POSTBYTE_OP, 16'h0, 16'h0, 5'h10));
         run(CL_LOOP, '{o, h, l}, mk(AM_POSTBYTE_OP, 16'h0, 16'h0, 5'h10));
      end
      $display("test plain modes done");
   endtask : test_plain

   // constant offsets, accumulator offsets and both indirect forms, per base
   task automatic test_index();
      logic [7:0] h, l;
      logic [4:0] n5;
      logic [1:0] rr, aa;
      logic [15:0] off;
      for (int i = 0; i < 16; i++) begin
         new_regs(i == 5);
         rr = i[1:0];
         aa = i[3:2];
         h = 8'($urandom);
         l = 8'($urandom);
         slow <= i[2];
         n5 = i < 4 ? 5'h10 : i < 8 ? 5'h0f : l[4:0];
         run(CL_IDX, '{rop(), {rr, 1'b0, n5}},
             mk(AM_SHORT_INDEXED, base(rr) + {{11{n5[4]}}, n5}, 16'h0, 5'h19));
         run(CL_IDX, '{rop(), {3'h7, rr, 2'h0, i[3]}, l},
             mk(AM_NINE_BIT_INDEXED, base(rr) + {{8{i[3]}}, l}, 16'h0, 5'h19));
         run(CL_IDX, '{rop(), {3'h7, rr, 3'h2}, h, l},
             mk(AM_SIXTEEN_INDEXED, base(rr) + {h, l}, 16'h0, 5'h19));
         run(CL_IDX, '{rop(), {3'h7, rr, 3'h3}, h, l},
             mk(AM_OFFSET_INDIRECT, ptr(base(rr) + {h, l}), 16'h0, 5'h19));
         off = aa == AMD_AA_A ? {8'h00, ra} : aa == AMD_AA_B ? {8'h00, rb} : {ra, rb};
         run(CL_IDX, '{rop(), {3'h7, rr, 1'b1, aa}}, aa == AMD_AA_DIND ?
             mk(AM_DOUBLE_ACC_IND, ptr(base(rr) + off), 16'h0, 5'h19) :
             mk(AM_ACC_INDEXED, base(rr) + off, 16'h0, 5'h19));
      end
      $display("test indexed offsets done");
   endtask : test_index

   // steps +1, +8, -8, -1 in pre and post form on x, y and sp;
   // a pc code there would read as a 111rr postbyte, so pc never reaches this form
   task automatic test_auto();
      logic [1:0] rr;
      logic [3:0] nib;
      logic [15:0] nb;
      amd_tb_exp_s e;
      for (int i = 0; i < 32; i++) begin
         new_regs();
         rr = i[1:0] == AMD_RR_PC ? {1'b0, i[3]} : i[1:0];
         nib = {i[4], {3{i[3]}}};
         nb = base(rr) + (nib[3] ? {12'hfff, nib} : {12'h000, nib} + 16'h1);
         e = mk(AM_AUTO_INDEXED, i[2] ? base(rr) : nb, 16'h0, 5'h19);
         e.ill = rr == AMD_RR_PC;
         if (rr != AMD_RR_PC) wb_q.push_back({rr, nb});
         run(CL_IDX, '{rop(), {rr, 1'b1, i[2], nib}}, e);
      end
      $display("test auto step done");
   endtask : test_auto

   // result watcher: oldest note against each ea_valid_o pulse
   always @(negedge sys_clk_i) begin : mon_ea
      amd_tb_exp_s e;
      logic [7:0]  eo;
      // opcode pulse belongs to the instruction at the head of the queue
      eo = exp_q.size() != 0 ? exp_q[0].opc : ~opcode_o;
      if (opcode_valid_o === 1'b1) cmp16("opcode_valid", {8'h0, eo}, {8'h0, opcode_o});
      if (ea_valid_o === 1'b1 && exp_q.size() == 0) cmp16("ea_valid", 16'h0, 16'h1);
      else if (ea_valid_o === 1'b1) begin
         e = exp_q.pop_front();
         cmp_mode(e.mode, mode_o);
         cmp16("opcode", {e.pg2, 7'h0, e.opc}, {page2_o, 7'h0, opcode_o});
         if (e.chk[0]) cmp16("ea", e.ea, ea_o);
         if (e.chk[1]) cmp16("operand", e.opnd, operand_o);
         if (e.chk[2]) cmp16("no_mem", {15'h0, e.nomem}, {15'h0, no_mem_o});
         if (e.chk[3]) cmp16("illegal", {15'h0, e.ill}, {15'h0, illegal_o});
         if (e.chk[4]) cmp16("postbyte", {8'h0, e.pb}, {8'h0, postbyte_o});
      end
   end

   // write-back watcher; a pulse with nothing noted is a mismatch
   always @(negedge sys_clk_i) begin : mon_wb
      logic [17:0] w;
      if (wb_valid_o === 1'b1) begin
         w = wb_q.size() != 0 ? wb_q.pop_front() : {2'h3, ~wb_value_o};
         cmp16("wb_sel", {14'h0, w[17:16]}, {14'h0, wb_sel_o});
         cmp16("wb_value", w[15:0], wb_value_o);
      end
   end

   initial begin
      {sys_clk_i, q_valid_i, slow, q_byte_i} = '0;
      {reg_x_i, reg_y_i, reg_sp_i, reg_pc_i, acc_a_i, acc_b_i} = '0;
      sys_rst_i = 1'b1;
      op_class_i = CL_INH;
      err_count = 0;
      checks = 0;
      void'($urandom(32'hbe15));
      repeat (12) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      test_plain();
      test_index();
      test_auto();
      repeat (4) @(posedge sys_clk_i);
      cmp16("wb pending", 16'h0, 16'(wb_q.size()));
      print_verdict();
   end
endmodule : tb_amd_addr_decoder
